// ===== ascp_async_serial_channel.sv
// One polled asynchronous serial channel with byte-wide host port
`timescale 1ns/1ps
//
// How it works
// - Status bit 0 set while characters wait
// - Receive buffer holds three characters
// - Reading last character clears bit 0
// - Null character with framing error flags break
// - Reset-status command reloads live line values
// - Carrier detect shown in status bit 3
// - Clear-to-send shown in status bit 5
// - Status bit 2 means transmit buffer empty
// - Error bits: framing 6, overrun 5, parity 4
// - Fourth unread character raises overrun
// - Overrun and parity stick until error reset
// - Reset-status command keeps error latches
// - Framing error follows each character
// - Line transitions latched, two remembered
// - One command byte sets pointer and command
// - Receiver runs only with enable bit
// - Channel reset command restores reset state
// - Mode supports divide-by-64, two stops, parity
// - Control registers hold character and enable settings
// - Other registers take pointer then value
// - Carrier and clear-to-send status bits are inverse of line pins
// - Auto enables gate on low carrier, clear
module ascp_async_serial_channel (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic sel_in,
  input wire logic ctrl_sel_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  input wire logic rx_tick_in,
  input wire logic tx_tick_in,
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic dcd_n_in,
  input wire logic cts_n_in,
  output logic rts_n_out,
  output logic dtr_n_out
);
  logic [7:0] ptr_q, rxctl, mode, txctl;
  logic [7:0] next_rxctl, next_mode, next_txctl, next_data;
  logic [2:0] ptr, next_ptr, cmd;
  logic wr_ctl, wr_dat, rd_ctl, rd_dat, is_cmd;
  logic do_ch_rst, do_rst_ext, do_err_rst, ch_rst;
  logic [7:0] ps, es;
  ascp_pkg::ascp_ext_s live, ext_st, next_ext_st;
  logic ext_lock, next_ext_lock, ext_pend, next_ext_pend;
  logic par_q, next_par, ovr_q, next_ovr;
  logic rx_valid, rx_perr, rx_brk, rx_gate, fifo_avail, fifo_ovr;
  ascp_pkg::ascp_char_s rx_char, head;
  logic [7:0] tx_buf, next_tx_buf;
  logic tx_full, next_tx_full, tx_gate, next_txd, par_bit, two_stop;
  logic [11:0] tx_sh, next_tx_sh;
  logic [3:0] tx_left, next_tx_left;
  logic [6:0] tx_cnt, next_tx_cnt, tx_div;

  assign ptr = ptr_q[2:0];

  // Host access decode: select routes data or control path
  assign wr_ctl = sel_in && wr_in && ctrl_sel_in;
  assign wr_dat = sel_in && wr_in && !ctrl_sel_in;
  assign rd_ctl = sel_in && rd_in && ctrl_sel_in;
  assign rd_dat = sel_in && rd_in && !ctrl_sel_in;
  assign cmd = data_in[ascp_pkg::CMD_LSB +: 3];
  assign is_cmd = wr_ctl && (ptr == ascp_pkg::PTR_PRIMARY);

  // Commands carried in a pointer byte
  assign do_ch_rst = is_cmd && (cmd == ascp_pkg::CMD_CH_RST);
  assign do_rst_ext = is_cmd && (cmd == ascp_pkg::CMD_RST_EXT);
  assign do_err_rst = is_cmd && (cmd == ascp_pkg::CMD_ERR_RST);
  assign ch_rst = sys_rst_in || (ce_in && do_ch_rst);

  // Auto enables gate receiver and transmitter on low modem lines
  assign rx_gate = rxctl[ascp_pkg::RC_RX_EN]
    && (!rxctl[ascp_pkg::RC_AUTO] || !dcd_n_in);
  assign tx_gate = txctl[ascp_pkg::TC_TX_EN]
    && (!rxctl[ascp_pkg::RC_AUTO] || !cts_n_in);

  // Modem outputs follow the transmit control bits
  assign rts_n_out = !txctl[ascp_pkg::TC_RTS];
  assign dtr_n_out = !txctl[ascp_pkg::TC_DTR];

  ascp_rx_deser u_deser (
    .clk_in(clk_in),
    .rst_in(ch_rst),
    .ce_in(ce_in),
    .tick_in(rx_tick_in),
    .clk_sel_in(mode[ascp_pkg::AM_CLK_LSB +: 2]),
    .enable_in(rx_gate),
    .par_en_in(mode[ascp_pkg::AM_PAR_EN]),
    .par_even_in(mode[ascp_pkg::AM_PAR_EVEN]),
    .rxd_in(rxd_in),
    .valid_out(rx_valid),
    .char_out(rx_char),
    .par_err_out(rx_perr),
    .brk_out(rx_brk)
  );

  ascp_rx_fifo u_fifo (
    .clk_in(clk_in),
    .rst_in(ch_rst),
    .ce_in(ce_in),
    .push_in(rx_valid),
    .wdata_in(rx_char),
    .pop_in(rd_dat),
    .rdata_out(head),
    .avail_out(fifo_avail),
    .overrun_out(fifo_ovr)
  );

  // Primary and error status assembly
  always_comb begin
    ps = ascp_pkg::REG_RST;
    ps[ascp_pkg::PS_RX_AVAIL] = fifo_avail;
    ps[ascp_pkg::PS_TX_EMPTY] = !tx_full;
    ps[ascp_pkg::PS_DCD] = ext_st.dcd;
    ps[ascp_pkg::PS_CTS] = ext_st.cts;
    ps[ascp_pkg::PS_BREAK] = ext_st.brk;
    es = ascp_pkg::REG_RST;
    es[ascp_pkg::ES_ALL_SENT] = !tx_full && (tx_left == 4'h0);
    es[ascp_pkg::ES_PARITY] = par_q;
    es[ascp_pkg::ES_OVERRUN] = ovr_q;
    es[ascp_pkg::ES_FRAMING] = fifo_avail && head.framing;
  end

  // Pointer, control registers and read data
  always_comb begin
    next_ptr = ptr;
    next_rxctl = rxctl;
    next_mode = mode;
    next_txctl = txctl;
    next_data = data_out;
    if (wr_ctl) begin
      if (ptr == ascp_pkg::PTR_PRIMARY) begin
        next_ptr = data_in[2:0];
      end else begin
        next_ptr = ascp_pkg::PTR_PRIMARY;
        if (ptr == ascp_pkg::PTR_RXCTL) begin
          next_rxctl = data_in;
        end else if (ptr == ascp_pkg::PTR_MODE) begin
          next_mode = data_in;
        end else if (ptr == ascp_pkg::PTR_TXCTL) begin
          next_txctl = data_in;
        end
      end
    end else if (rd_ctl) begin
      next_ptr = ascp_pkg::PTR_PRIMARY;
      next_data = (ptr == ascp_pkg::PTR_ERR) ? es : ps;
    end else if (rd_dat) begin
      next_data = head.data;
    end
  end

  // External status latch with one pending transition
  assign live = {rx_brk, !cts_n_in, !dcd_n_in};
  always_comb begin
    next_ext_st = ext_st;
    next_ext_lock = ext_lock;
    next_ext_pend = ext_pend;
    if (do_rst_ext) begin
      next_ext_st = live;
      next_ext_lock = ext_pend;
      next_ext_pend = 1'b0;
    end else if (!ext_lock) begin
      if (live != ext_st) begin
        next_ext_st = live;
        next_ext_lock = 1'b1;
      end
    end else if (live != ext_st) begin
      next_ext_pend = 1'b1;
    end
  end

  // Sticky error latches, a new error wins over the reset
  always_comb begin
    next_par = (par_q && !do_err_rst) || (rx_valid && rx_perr);
    next_ovr = (ovr_q && !do_err_rst) || fifo_ovr;
  end

  // Transmit buffer and shifter
  assign tx_div = ascp_pkg::ascp_div(mode[ascp_pkg::AM_CLK_LSB +: 2]);
  assign par_bit = (^tx_buf) ^ !mode[ascp_pkg::AM_PAR_EVEN];
  assign two_stop = (mode[ascp_pkg::AM_STOP_LSB +: 2] == ascp_pkg::STOP_TWO);
  always_comb begin
    next_tx_buf = tx_buf;
    next_tx_full = tx_full;
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_tx_cnt = tx_cnt;
    if (tx_tick_in && tx_cnt != 7'h00) begin
      next_tx_cnt = tx_cnt - 7'h01;
    end
    if (tx_left != 4'h0) begin
      if (tx_tick_in && tx_cnt == 7'h00) begin
        next_tx_sh = {1'b1, tx_sh[11:1]};
        next_tx_left = tx_left - 4'h1;
        next_tx_cnt = tx_div - 7'h01;
      end
    end else if (tx_full && tx_gate) begin
      if (mode[ascp_pkg::AM_PAR_EN]) begin
        next_tx_sh = {2'h3, par_bit, tx_buf, 1'b0};
      end else begin
        next_tx_sh = {3'h7, tx_buf, 1'b0};
      end
      next_tx_left = ascp_pkg::TX_BITS_BASE + {3'h0, mode[ascp_pkg::AM_PAR_EN]}
        + {3'h0, two_stop};
      next_tx_cnt = tx_div - 7'h01;
      next_tx_full = 1'b0;
    end
    if (wr_dat && !tx_full) begin
      next_tx_buf = data_in;
      next_tx_full = 1'b1;
    end
    if (txctl[ascp_pkg::TC_BREAK]) begin
      next_txd = 1'b0;
    end else begin
      next_txd = (tx_left != 4'h0) ? tx_sh[0] : 1'b1;
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clk_in) begin
    if (ch_rst) begin
      ptr_q <= ascp_pkg::REG_RST;
      rxctl <= ascp_pkg::REG_RST;
      mode <= ascp_pkg::REG_RST;
      txctl <= ascp_pkg::REG_RST;
      data_out <= ascp_pkg::REG_RST;
      ext_st <= '0;
      ext_lock <= 1'b0;
      ext_pend <= 1'b0;
      par_q <= 1'b0;
      ovr_q <= 1'b0;
      tx_buf <= ascp_pkg::REG_RST;
      tx_full <= 1'b0;
      tx_sh <= '1;
      tx_left <= 4'h0;
      tx_cnt <= 7'h00;
      txd_out <= 1'b1;
    end else if (ce_in) begin
      ptr_q <= {5'h00, next_ptr};
      rxctl <= next_rxctl;
      mode <= next_mode;
      txctl <= next_txctl;
      data_out <= next_data;
      ext_st <= next_ext_st;
      ext_lock <= next_ext_lock;
      ext_pend <= next_ext_pend;
      par_q <= next_par;
      ovr_q <= next_ovr;
      tx_buf <= next_tx_buf;
      tx_full <= next_tx_full;
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      tx_cnt <= next_tx_cnt;
      txd_out <= next_txd;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_point_mode;
    ce_in && wr_ctl && ptr == ascp_pkg::PTR_PRIMARY && !do_ch_rst
      && data_in[2:0] == ascp_pkg::PTR_MODE;
  endsequence
  sequence s_err_cmd;
    ce_in && do_err_rst && !(rx_valid && rx_perr) && !fifo_ovr;
  endsequence

  a_avail_flag: assert property (
    ce_in && rx_valid && !do_ch_rst |=> ps[0])
    else $error("available flag not set after receive");
  a_ext_reload: assert property (
    ce_in && do_rst_ext |=> ext_st == $past(live))
    else $error("status not reloaded from lines");
  a_dcd_invert: assert property (
    ce_in && do_rst_ext |=> ps[3] == !$past(dcd_n_in))
    else $error("carrier bit not inverse of pin");
  a_cts_invert: assert property (
    ce_in && do_rst_ext |=> ps[5] == !$past(cts_n_in))
    else $error("clear-to-send bit not inverse of pin");
  a_tx_empty: assert property (
    ce_in && wr_dat && !tx_full && !do_ch_rst |=> !ps[2] && tx_buf == $past(data_in))
    else $error("transmit buffer not marked full");
  a_err_clear: assert property (
    s_err_cmd |=> !par_q && !ovr_q)
    else $error("error reset left latches set");
  a_err_kept: assert property (
    ce_in && do_rst_ext && par_q |=> par_q)
    else $error("status reset cleared parity latch");
  a_two_writes: assert property (
    s_point_mode ##1 ce_in && wr_ctl |=> mode == $past(data_in) && ptr == 3'h0)
    else $error("pointer write sequence failed");
endmodule

// ===== ascp_pkg.sv
// Constants, types and register layout for the async serial channel
package ascp_pkg;
  // Pointer values selecting a target register
  localparam logic [2:0] PTR_PRIMARY = 3'h0;
  localparam logic [2:0] PTR_ERR = 3'h1;
  localparam logic [2:0] PTR_RXCTL = 3'h3;
  localparam logic [2:0] PTR_MODE = 3'h4;
  localparam logic [2:0] PTR_TXCTL = 3'h5;
  // Command codes in bits 5..3 of a command byte
  localparam logic [2:0] CMD_RST_EXT = 3'h2;
  localparam logic [2:0] CMD_CH_RST = 3'h3;
  localparam logic [2:0] CMD_ERR_RST = 3'h6;
  localparam int CMD_LSB = 3;
  // Primary status bits
  localparam int PS_RX_AVAIL = 0;
  localparam int PS_TX_EMPTY = 2;
  localparam int PS_DCD = 3;
  localparam int PS_CTS = 5;
  localparam int PS_BREAK = 7;
  // Error status bits: all sent and receive errors
  localparam int ES_ALL_SENT = 0;
  localparam int ES_PARITY = 4;
  localparam int ES_OVERRUN = 5;
  localparam int ES_FRAMING = 6;
  // Control register fields
  localparam int RC_RX_EN = 0;
  localparam int RC_AUTO = 5;
  localparam int TC_RTS = 1;
  localparam int TC_TX_EN = 3;
  localparam int TC_BREAK = 4;
  localparam int TC_DTR = 7;
  localparam int AM_PAR_EN = 0;
  localparam int AM_PAR_EVEN = 1;
  localparam int AM_STOP_LSB = 2;
  localparam int AM_CLK_LSB = 6;
  localparam logic [1:0] STOP_TWO = 2'h3;
  // Reset values and sizes
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int RX_DEPTH = 3;
  localparam logic [3:0] TX_BITS_BASE = 4'ha;
  // Clock division counts
  localparam logic [6:0] DIV_X1 = 7'h01;
  localparam logic [6:0] DIV_X16 = 7'h10;
  localparam logic [6:0] DIV_X32 = 7'h20;
  localparam logic [6:0] DIV_X64 = 7'h40;

  typedef struct packed {
    logic framing;
    logic [7:0] data;
  } ascp_char_s;

  typedef struct packed {
    logic brk;
    logic cts;
    logic dcd;
  } ascp_ext_s;

  // Input clock ticks per bit for a clock-mode field
  function automatic logic [6:0] ascp_div(input logic [1:0] sel);
    case (sel)
      2'h0: ascp_div = DIV_X1;
      2'h1: ascp_div = DIV_X16;
      2'h2: ascp_div = DIV_X32;
      default: ascp_div = DIV_X64;
    endcase
  endfunction
endpackage

// ===== ascp_rx_fifo.sv
// Three-entry receive character buffer with overrun overwrite
`timescale 1ns/1ps
module ascp_rx_fifo (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic push_in,
  input wire ascp_pkg::ascp_char_s wdata_in,
  input wire logic pop_in,
  output ascp_pkg::ascp_char_s rdata_out,
  output logic avail_out,
  output logic overrun_out
);
  ascp_pkg::ascp_char_s mem [ascp_pkg::RX_DEPTH];
  ascp_pkg::ascp_char_s next_mem [ascp_pkg::RX_DEPTH];
  logic [1:0] rd, next_rd, cnt, next_cnt;
  logic next_ovr, do_pop;

  // Index arithmetic modulo the depth
  function automatic logic [1:0] wrap(input logic [1:0] base, input logic [1:0] off);
    logic [2:0] s;
    s = {1'b0, base} + {1'b0, off};
    wrap = (s >= 3'(ascp_pkg::RX_DEPTH)) ? 2'(s - 3'(ascp_pkg::RX_DEPTH)) : s[1:0];
  endfunction

  assign avail_out = (cnt != 2'h0);
  assign rdata_out = mem[rd];
  assign do_pop = pop_in && avail_out;

  // Push, pop and overwrite of the newest entry when full
  always_comb begin
    next_mem = mem;
    next_rd = rd;
    next_cnt = cnt;
    next_ovr = 1'b0;
    if (do_pop) begin
      next_rd = wrap(rd, 2'h1);
      next_cnt = cnt - 2'h1;
    end
    if (push_in) begin
      if (cnt == 2'(ascp_pkg::RX_DEPTH) && !do_pop) begin
        next_mem[wrap(rd, cnt - 2'h1)] = wdata_in;
        next_ovr = 1'b1;
      end else begin
        next_mem[wrap(rd, cnt)] = wdata_in;
        next_cnt = next_cnt + 2'h1;
      end
    end
  end

  // Buffer state registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd <= 2'h0;
      cnt <= 2'h0;
      overrun_out <= 1'b0;
    end else if (ce_in) begin
      mem <= next_mem;
      rd <= next_rd;
      cnt <= next_cnt;
      overrun_out <= next_ovr;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_fifo_order: assert property (
    ce_in && push_in && cnt == 2'h0 |=> rdata_out == $past(wdata_in))
    else $error("oldest character not at head");
  a_fifo_overrun: assert property (
    ce_in && push_in && !pop_in && cnt == 2'h3 |=> overrun_out && cnt == 2'h3)
    else $error("overrun not flagged on full buffer");
  a_last_clears: assert property (
    ce_in && pop_in && !push_in && cnt == 2'h1 |=> !avail_out)
    else $error("available flag kept after last read");
  a_holds_three: assert property (
    ce_in && push_in && !pop_in && cnt == 2'h2 |=> cnt == 2'h3 && !overrun_out)
    else $error("third character not held");
endmodule

// ===== ascp_rx_deser.sv
// Receive deserialiser: start detect, sampling, parity, stop and break
`timescale 1ns/1ps
module ascp_rx_deser (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic [1:0] clk_sel_in,
  input wire logic enable_in,
  input wire logic par_en_in,
  input wire logic par_even_in,
  input wire logic rxd_in,
  output logic valid_out,
  output ascp_pkg::ascp_char_s char_out,
  output logic par_err_out,
  output logic brk_out
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_LOW} ascp_rx_e;
  ascp_rx_e state, next_state;
  logic [6:0] cnt, next_cnt, div;
  logic [2:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic pbit, next_pbit, next_valid, next_perr, next_brk, due;
  ascp_pkg::ascp_char_s next_char;

  assign div = ascp_pkg::ascp_div(clk_sel_in);
  assign due = tick_in && (cnt == 7'h00);

  // Receive sequencer, one sample per bit period
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    next_pbit = pbit;
    next_valid = 1'b0;
    next_char = char_out;
    next_perr = 1'b0;
    next_brk = brk_out && !rxd_in;
    if (tick_in && cnt != 7'h00) begin
      next_cnt = cnt - 7'h01;
    end
    case (state)
      S_IDLE: if (!rxd_in) begin
        next_state = S_START;
        next_cnt = div >> 1;
      end
      S_START: if (due) begin
        next_state = rxd_in ? S_IDLE : S_DATA;
        next_cnt = div - 7'h01;
        next_bitn = 3'h0;
      end
      S_DATA: if (due) begin
        next_sh = {rxd_in, sh[7:1]};
        next_bitn = bitn + 3'h1;
        next_cnt = div - 7'h01;
        if (bitn == 3'h7) begin
          next_state = par_en_in ? S_PAR : S_STOP;
        end
      end
      S_PAR: if (due) begin
        next_pbit = rxd_in;
        next_cnt = div - 7'h01;
        next_state = S_STOP;
      end
      S_STOP: if (due) begin
        next_valid = 1'b1;
        next_char = {!rxd_in, sh};
        next_perr = par_en_in && ((^sh ^ pbit) == par_even_in);
        if (!rxd_in && sh == 8'h00) begin
          next_brk = 1'b1;
        end
        next_state = rxd_in ? S_IDLE : S_LOW;
      end
      S_LOW: if (rxd_in) begin
        next_state = S_IDLE;
      end
      default: next_state = S_IDLE;
    endcase
    if (!enable_in) begin
      next_state = S_IDLE;
      next_valid = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      cnt <= 7'h00;
      bitn <= 3'h0;
      sh <= 8'h00;
      pbit <= 1'b0;
      valid_out <= 1'b0;
      char_out <= '0;
      par_err_out <= 1'b0;
      brk_out <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
      pbit <= next_pbit;
      valid_out <= next_valid;
      char_out <= next_char;
      par_err_out <= next_perr;
      brk_out <= next_brk;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_null_stop;
    ce_in && enable_in && state == S_STOP && due && !rxd_in && sh == 8'h00;
  endsequence
  a_break_flag: assert property (
    s_null_stop |=> brk_out && valid_out && char_out.framing)
    else $error("break not reported");
  a_rx_gated: assert property (
    ce_in && !enable_in |=> state == S_IDLE && !valid_out)
    else $error("receiver ran while disabled");
endmodule

// ===== ascp_line_model.sv
// Serial line partner: baud ticks and receive character frames
`timescale 1ns/1ps
module ascp_line_model (
  input wire logic clk_in,
  output logic rxd_out,
  output logic rx_tick_out,
  output logic tx_tick_out
);
  localparam int BIT_CYC = 64;

  // Line idles high, baud ticks run free every cycle
  initial begin
    rxd_out = 1'b1;
    rx_tick_out = 1'b1;
    tx_tick_out = 1'b1;
  end

  // Holds one bit level for a full bit time at divide-by-64
  task automatic put_bit(input logic b);
    rxd_out <= b;
    repeat (BIT_CYC) @(posedge clk_in);
  endtask

  // Start, eight data LSB first, odd parity, two stops; faults on request
  task automatic send(input logic [7:0] d, input logic par_ok, input logic stop_ok,
                      input logic hold);
    @(posedge clk_in);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) begin
      put_bit(d[i]);
    end
    put_bit(~^d ^ ~par_ok);
    put_bit(stop_ok);
    if (!hold) begin
      put_bit(1'b1);
    end
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the polled async serial channel
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, ctl = 1'b0, rd = 1'b0, wr = 1'b0, ce = 1'b1;
  logic [7:0] din = 8'h00, dout, v, t;
  logic dcd_n = 1'b1, cts_n = 1'b1, rxd, rtk, ttk, txd, rts_n, dtr_n, p;
  logic [7:0] ini [6] = '{8'h14, 8'hcd, 8'h13, 8'he1, 8'h15, 8'hea};
  logic [7:0] ovr [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
  int miscompares = 0, comparisons = 0;

  // Clock of 100 ns period
  always #50 clk = ~clk;

  ascp_line_model u_line (.clk_in(clk), .rxd_out(rxd), .rx_tick_out(rtk), .tx_tick_out(ttk));
  ascp_async_serial_channel u_dut (.clk_in(clk), .sys_rst_in(rst), .ce_in(ce), .sel_in(sel),
    .ctrl_sel_in(ctl), .rd_in(rd), .wr_in(wr), .data_in(din), .data_out(dout),
    .rx_tick_in(rtk), .tx_tick_in(ttk), .rxd_in(rxd), .txd_out(txd), .dcd_n_in(dcd_n),
    .cts_n_in(cts_n), .rts_n_out(rts_n), .dtr_n_out(dtr_n));

  // Counts and verdict, then end of run
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One host access held for one taking edge; read data lands in v
  task automatic bus(input logic c, input logic w, input logic [7:0] d);
    @(posedge clk);
    sel <= 1'b1;
    ctl <= c;
    wr <= w;
    rd <= ~w;
    din <= d;
    @(posedge clk);
    sel <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = dout;
  endtask

  // Error status read: pointer byte then control read
  task automatic rd_err();
    bus(1'b1, 1'b1, 8'h01);
    bus(1'b1, 1'b0, 8'h00);
  endtask

  // Captures one frame on the transmit line, bounded wait for start
  task automatic get_tx(output logic [7:0] d, output logic par);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      wrap_up();
    end
    repeat (32) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (64) @(posedge clk);
      d[i] = txd;
    end
    repeat (64) @(posedge clk);
    par = txd;
    repeat (64) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b1, 1'b1, 8'h18);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("primary after channel reset", 8'h04, v & 8'had)
    // Setup bytes back to back, one write per cycle
    @(posedge clk);
    foreach (ini[i]) begin
      sel <= 1'b1;
      ctl <= 1'b1;
      wr <= 1'b1;
      din <= ini[i];
      @(posedge clk);
    end
    sel <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    `CHK("rts dtr", 2'h0, {rts_n, dtr_n})
    u_line.send(8'h3c, 1'b1, 1'b1, 1'b0);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("no rx without carrier", 1'b0, v[0])
    @(posedge clk);
    dcd_n <= 1'b0;
    cts_n <= 1'b0;
    bus(1'b1, 1'b1, 8'h10);
    bus(1'b1, 1'b1, 8'h10);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("carrier and clear status", 8'h28, v & 8'h28)
    for (int i = 0; i < 3; i++) u_line.send(ovr[i] + 8'h90, 1'b1, 1'b1, 1'b0);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("char available", 1'b1, v[0])
    rd_err();
    `CHK("clean errors", 8'h00, v & 8'h70)
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 1'b0, 8'h00);
      `CHK("fifo order", ovr[i] + 8'h90, v)
    end
    bus(1'b1, 1'b0, 8'h00);
    `CHK("available cleared", 1'b0, v[0])
    foreach (ovr[i]) u_line.send(ovr[i], 1'b1, 1'b1, 1'b0);
    rd_err();
    `CHK("overrun set", 8'h20, v & 8'h70)
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, 1'b0, 8'h00);
      `CHK("overrun data", (i == 2) ? 8'h44 : ovr[i], v)
    end
    rd_err();
    `CHK("overrun sticky", 8'h20, v & 8'h70)
    bus(1'b1, 1'b1, 8'h30);
    rd_err();
    `CHK("overrun cleared", 8'h00, v & 8'h70)
    u_line.send(8'h5a, 1'b0, 1'b1, 1'b0);
    rd_err();
    `CHK("parity error", 8'h10, v & 8'h70)
    bus(1'b0, 1'b0, 8'h00);
    bus(1'b1, 1'b1, 8'h10);
    rd_err();
    `CHK("parity kept", 8'h10, v & 8'h70)
    bus(1'b1, 1'b1, 8'h30);
    u_line.send(8'h55, 1'b1, 1'b0, 1'b0);
    rd_err();
    `CHK("framing error", 8'h40, v & 8'h70)
    bus(1'b0, 1'b0, 8'h00);
    u_line.send(8'h66, 1'b1, 1'b1, 1'b0);
    rd_err();
    `CHK("framing per char", 8'h00, v & 8'h70)
    bus(1'b0, 1'b0, 8'h00);
    `CHK("good char", 8'h66, v)
    u_line.send(8'h00, 1'b0, 1'b0, 1'b1);
    bus(1'b1, 1'b1, 8'h10);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("break seen", 8'h81, v & 8'h81)
    @(posedge clk);
    u_line.put_bit(1'b1);
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 1'b0, 8'h00);
      if (v[0] !== 1'b1) break;
      bus(1'b0, 1'b0, 8'h00);
    end
    bus(1'b1, 1'b1, 8'h30);
    bus(1'b1, 1'b1, 8'h10);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("break ended", 8'h00, v & 8'h81)
    // Data write while frozen must be ignored
    @(posedge clk);
    ce <= 1'b0;
    bus(1'b0, 1'b1, 8'h77);
    @(posedge clk);
    ce <= 1'b1;
    bus(1'b1, 1'b0, 8'h00);
    `CHK("tx empty before write", 1'b1, v[2])
    bus(1'b0, 1'b1, 8'h5a);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("tx empty after load", 1'b1, v[2])
    bus(1'b0, 1'b1, 8'hc3);
    bus(1'b1, 1'b0, 8'h00);
    `CHK("tx buffer full", 1'b0, v[2])
    get_tx(t, p);
    `CHK("tx first char", 8'h5a, t)
    `CHK("tx odd parity", ~^t, p)
    get_tx(t, p);
    `CHK("tx second char", 8'hc3, t)
    bus(1'b1, 1'b0, 8'h00);
    `CHK("tx empty again", 1'b1, v[2])
    // Two line transitions, the second stays pending
    @(posedge clk);
    dcd_n <= 1'b1;
    repeat (2) @(posedge clk);
    cts_n <= 1'b1;
    bus(1'b1, 1'b0, 8'h00);
    `CHK("first transition latched", 8'h20, v & 8'h28)
    bus(1'b1, 1'b1, 8'h10);
    @(posedge clk);
    dcd_n <= 1'b0;
    bus(1'b1, 1'b0, 8'h00);
    `CHK("pending transition locks", 8'h00, v & 8'h28)
    bus(1'b1, 1'b1, 8'h18);
    `CHK("rts dtr after channel reset", 2'h3, {rts_n, dtr_n})
    wrap_up();
  end
endmodule
